// >>> xag_pkg.sv
package xag_pkg;

	// ------------------------------------------------------------
	// special function register addresses
	// ------------------------------------------------------------
	localparam logic [7:0] XAG_SP_ADDR   = 8'h81;
	localparam logic [7:0] XAG_P4_ADDR   = 8'h92;
	localparam logic [7:0] XAG_ESP_ADDR  = 8'h9b;
	localparam logic [7:0] XAG_AP_ADDR   = 8'h9c;
	localparam logic [7:0] XAG_ADDRESS_CONTROL_ADDR = 8'h9d;
	localparam logic [7:0] XAG_P2_ADDR   = 8'ha0;
	localparam logic [7:0] XAG_P5_ADDR   = 8'ha2;
	localparam logic [7:0] XAG_P6_ADDR   = 8'hb2;
	localparam logic [7:0] XAG_INDIRECT_EXTENDED_BYTE_ADDR = 8'hea;
	localparam logic [7:0] XAG_TA_ADDR   = 8'hc7;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] XAG_SP_RST   = 8'h07;
	localparam logic [7:0] XAG_P4_RST   = 8'h3f;
	localparam logic [7:0] XAG_ESP_RST  = 8'h00;
	localparam logic [7:0] XAG_AP_RST   = 8'h00;
	localparam logic [7:0] XAG_ADDRESS_CONTROL_RST = 8'h00;
	localparam logic [7:0] XAG_P2_RST   = 8'hff;
	localparam logic [7:0] XAG_P5_RST   = 8'h00;
	localparam logic [7:0] XAG_P6_RST   = 8'h00;
	localparam logic [7:0] XAG_INDIRECT_EXTENDED_BYTE_RST = 8'h00;

	// ------------------------------------------------------------
	// field positions and protected bit masks
	// ------------------------------------------------------------
	localparam int XAG_MODE_LSB   = 0;
	localparam int XAG_STACK_BIT  = 2;
	localparam int XAG_COUNT_LSB  = 0;
	localparam int XAG_SIZE_LSB   = 3;
	localparam logic [7:0] XAG_P4_PROT   = 8'h3f;
	localparam logic [7:0] XAG_ADDRESS_CONTROL_PROT = 8'h07;
	localparam logic [7:0] XAG_P5_PROT   = 8'h07;
	localparam logic [7:0] XAG_P6_PROT   = 8'h3f;

	// ------------------------------------------------------------
	// codes and timing counts
	// ------------------------------------------------------------
	localparam logic [1:0] XAG_MODE_16    = 2'b00;
	localparam logic [1:0] XAG_MODE_PAGED = 2'b01;
	localparam logic [7:0] XAG_TA_KEY1    = 8'haa;
	localparam logic [7:0] XAG_TA_KEY2    = 8'h55;
	localparam logic [1:0] XAG_TA_CYCLES  = 2'd3;
	localparam logic [1:0] XAG_STRAP_WAIT = 2'd2;
	localparam logic [2:0] XAG_PINS_FIRST = 3'b100;
	localparam logic [2:0] XAG_PROG_SIZE_MAX = 3'b110;
	localparam logic [2:0] XAG_DATA_SIZE_MAX = 3'b100;
	localparam logic [4:0] XAG_SHIFT_32K  = 5'd15;
	localparam logic [4:0] XAG_SHIFT_BASE = 5'd16;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		XAG_REQ_FETCH,
		XAG_REQ_VECTOR,
		XAG_REQ_POINTER,
		XAG_REQ_INDIRECT
	} xag_kind_t;

	typedef enum logic [1:0] {
		XAG_TA_IDLE,
		XAG_TA_ARMED,
		XAG_TA_OPEN
	} xag_ta_t;

	typedef struct packed {
		logic        valid;
		xag_kind_t   kind;
		logic [23:0] pc;
		logic [23:0] pointer;
		logic [7:0]  indirect_register;
	} xag_req_t;

	typedef struct packed {
		logic        valid;
		logic [23:0] address;
		logic [5:0]  addr_upper_en;
		logic [7:0]  port_two_out;
		logic [7:0]  addr_low_out;
		logic        addr_low_on_p7;
		logic [7:0]  program_enable_n;
		logic [3:0]  data_enable_n;
	} xag_pins_t;

	typedef struct packed {
		logic [1:0] addr_mode;
		logic       extra_call_ret_cycle;
		logic       extra_irq_cycle;
		logic       extra_inc_cycle;
		logic       pc_full_width;
		logic       vector_upper_zero;
	} xag_timing_t;

	typedef struct packed {
		logic [7:0] sp;
		logic [7:0] p4;
		logic [7:0] stack_pointer_high;
		logic [7:0] ap;
		logic [7:0] address_control;
		logic [7:0] p2;
		logic [7:0] p5;
		logic [7:0] p6;
		logic [7:0] indirect_extended_byte;
	} xag_regs_t;

endpackage

// >>> xag_sync.sv
`timescale 1ns/100ps
module xag_sync (
	input  wire logic mclk,
	input  wire logic sys_rst,
	input  wire logic din,
	output logic      dout
);
	logic meta_q;

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			meta_q <= 1'b0;
			dout   <= 1'b0;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule

// >>> xag_enable_decode.sv
`timescale 1ns/100ps
module xag_enable_decode import xag_pkg::*; #(
	parameter int         N        = 8,
	parameter logic [2:0] SIZE_MAX = 3'b110
) (
	input  wire logic         active,
	input  wire logic [23:0]  addr,
	input  wire logic [2:0]   size_code,
	input  wire logic [N-1:0] pin_mask,
	output logic [N-1:0]      enable_n
);
	logic [2:0]  code;
	logic [4:0]  shift;
	logic [23:0] region;

	always_comb begin
		code = (size_code > SIZE_MAX) ? SIZE_MAX : size_code;
		if (code == 3'b000) begin
			shift = XAG_SHIFT_32K;
		end else begin
			shift = XAG_SHIFT_BASE + {2'b00, code};
		end
		region = addr >> shift;
	end

	// one enable at most: region index above the per-enable size, only if a pin exists
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_en
			assign enable_n[i] = !(active && pin_mask[i] && (region == 24'(i)));
		end
	endgenerate
endmodule

// >>> xag_addr_gen.sv
`timescale 1ns/100ps
// Functional notes
// - two-bit mode field: 00 16-bit, 01 paged, upper bit set contiguous.
// - every reset returns the block to 16-bit addressing.
// - 16-bit mode confines program and data accesses to 64kB each.
// - paged mode adds a cycle to calls, returns and interrupt latency.
// - paged mode fetches interrupt vectors with upper two bytes zero.
// - contiguous mode uses full 24-bit program counter, saving three bytes.
// - contiguous mode lengthens pointer increment by one cycle, same byte count.
// - pointer data move uses pointer extended, high and low bytes.
// - indirect data move uses extended indirect byte, port 2 latch, register.
// - paged mode takes program address bits 23-16 from page byte.
// - stack address is extended stack byte over stack pointer byte when control bit 2 is set, else zero over stack pointer byte.
// - port 4 upper field picks how many of A16-A21 are address lines.
// - enable count fields: 000 none, 100 to 111 one to four pins.
// - lowest size code gives 32kB per program enable.
// - default size code gives 4MB per program enable, full 24-bit span.
// - port 5 field counts data enables; port 6 upper field sets reach.
// - up to four data enables, 4MB, sharing program address and data buses.
// - default bus drives high byte on port 2, low byte multiplexed on port 0.
// - bus mode strap caught at reset selects demultiplexed low byte on port 7.
module xag_addr_gen import xag_pkg::*; (
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic        bus_mode_strap,
	input  wire logic [7:0]  sfr_addr,
	input  wire logic        sfr_wr,
	input  wire logic        sfr_rd,
	input  wire logic [7:0]  sfr_wdata,
	output logic [7:0]       sfr_rdata,
	output logic             sfr_hit,
	input  wire xag_req_t    req,
	output xag_pins_t        pins,
	output xag_timing_t      timing,
	output logic [15:0]      stack_address
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	xag_regs_t   regs_q, regs_d;
	xag_ta_t     ta_q, ta_d;
	logic [1:0]  ta_cnt_q, ta_cnt_d;
	logic [7:0]  rdata_q, rdata_d;
	logic        hit_q, hit_d;
	logic        strap_s;
	logic [1:0]  strap_cnt_q, strap_cnt_d;
	logic        demux_q, demux_d;
	xag_pins_t   pins_q, pins_d;
	logic        ta_open;
	logic [1:0]  mode;
	logic [23:0] acc_addr;
	logic        is_prog;
	logic [7:0]  prog_mask;
	logic [3:0]  data_mask;
	logic [7:0]  prog_en_n;
	logic [3:0]  data_en_n;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
	                                     input logic [7:0] prot, input logic open);
		merge = open ? wd : ((old & prot) | (wd & ~prot));
	endfunction

	function automatic logic [3:0] pin_mask(input logic [2:0] code);
		unique case (code)
			3'b100:  pin_mask = 4'h1;
			3'b101:  pin_mask = 4'h3;
			3'b110:  pin_mask = 4'h7;
			3'b111:  pin_mask = 4'hf;
			default: pin_mask = 4'h0;
		endcase
	endfunction

	function automatic logic [5:0] upper_mask(input logic [2:0] code);
		unique case (code)
			3'b000:  upper_mask = 6'h00;
			3'b001:  upper_mask = 6'h01;
			3'b010:  upper_mask = 6'h03;
			3'b011:  upper_mask = 6'h07;
			3'b100:  upper_mask = 6'h0f;
			3'b101:  upper_mask = 6'h1f;
			default: upper_mask = 6'h3f;
		endcase
	endfunction

	// ------------------------------------------------------------
	// register file and timed access
	// ------------------------------------------------------------
	assign ta_open = (ta_q == XAG_TA_OPEN);

	always_comb begin
		regs_d   = regs_q;
		ta_d     = ta_q;
		ta_cnt_d = ta_cnt_q;
		rdata_d  = 8'h00;
		hit_d    = 1'b0;
		// window runs down on its own; a protected write also closes it
		if (ta_open) begin
			ta_cnt_d = ta_cnt_q - 2'd1;
			if (ta_cnt_q == 2'd1) begin
				ta_d = XAG_TA_IDLE;
			end
		end
		if (sfr_wr) begin
			if (sfr_addr == XAG_TA_ADDR) begin
				if (sfr_wdata == XAG_TA_KEY1) begin
					ta_d = XAG_TA_ARMED;
				end else if (sfr_wdata == XAG_TA_KEY2 && ta_q == XAG_TA_ARMED) begin
					ta_d     = XAG_TA_OPEN;
					ta_cnt_d = XAG_TA_CYCLES;
				end else begin
					ta_d = XAG_TA_IDLE;
				end
			end else begin
				if (ta_q == XAG_TA_ARMED) begin
					ta_d = XAG_TA_IDLE;
				end
				unique case (sfr_addr)
					XAG_SP_ADDR:   regs_d.sp   = sfr_wdata;
					XAG_ESP_ADDR:  regs_d.stack_pointer_high  = sfr_wdata;
					XAG_AP_ADDR:   regs_d.ap   = sfr_wdata;
					XAG_P2_ADDR:   regs_d.p2   = sfr_wdata;
					XAG_INDIRECT_EXTENDED_BYTE_ADDR: regs_d.indirect_extended_byte = sfr_wdata;
					XAG_P4_ADDR:   regs_d.p4   = merge(regs_q.p4, sfr_wdata, XAG_P4_PROT, ta_open);
					XAG_ADDRESS_CONTROL_ADDR: regs_d.address_control = merge(regs_q.address_control, sfr_wdata, XAG_ADDRESS_CONTROL_PROT,
					                                   ta_open);
					XAG_P5_ADDR:   regs_d.p5   = merge(regs_q.p5, sfr_wdata, XAG_P5_PROT, ta_open);
					XAG_P6_ADDR:   regs_d.p6   = merge(regs_q.p6, sfr_wdata, XAG_P6_PROT, ta_open);
					default: ;
				endcase
				if (ta_open && (sfr_addr == XAG_P4_ADDR || sfr_addr == XAG_ADDRESS_CONTROL_ADDR ||
				                sfr_addr == XAG_P5_ADDR || sfr_addr == XAG_P6_ADDR)) begin
					ta_d = XAG_TA_IDLE;
				end
			end
		end
		if (sfr_rd) begin
			hit_d = 1'b1;
			unique case (sfr_addr)
				XAG_SP_ADDR:   rdata_d = regs_q.sp;
				XAG_P4_ADDR:   rdata_d = regs_q.p4;
				XAG_ESP_ADDR:  rdata_d = regs_q.stack_pointer_high;
				XAG_AP_ADDR:   rdata_d = regs_q.ap;
				XAG_ADDRESS_CONTROL_ADDR: rdata_d = regs_q.address_control;
				XAG_P2_ADDR:   rdata_d = regs_q.p2;
				XAG_P5_ADDR:   rdata_d = regs_q.p5;
				XAG_P6_ADDR:   rdata_d = regs_q.p6;
				XAG_INDIRECT_EXTENDED_BYTE_ADDR: rdata_d = regs_q.indirect_extended_byte;
				default:       hit_d   = 1'b0;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			regs_q   <= '{sp: XAG_SP_RST, p4: XAG_P4_RST, stack_pointer_high: XAG_ESP_RST, ap: XAG_AP_RST,
			             address_control: XAG_ADDRESS_CONTROL_RST, p2: XAG_P2_RST, p5: XAG_P5_RST,
			             p6: XAG_P6_RST, indirect_extended_byte: XAG_INDIRECT_EXTENDED_BYTE_RST};
			ta_q     <= XAG_TA_IDLE;
			ta_cnt_q <= 2'd0;
			rdata_q  <= 8'h00;
			hit_q    <= 1'b0;
		end else begin
			regs_q   <= regs_d;
			ta_q     <= ta_d;
			ta_cnt_q <= ta_cnt_d;
			rdata_q  <= rdata_d;
			hit_q    <= hit_d;
		end
	end

	assign sfr_rdata = rdata_q;
	assign sfr_hit   = hit_q;

	// ------------------------------------------------------------
	// bus mode strap
	// ------------------------------------------------------------
	// the strap is caught after release, once the synchroniser has settled;
	// the second flop only shows the pin from the second edge, so catch on the third
	xag_sync u_strap_sync (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.din     (bus_mode_strap),
		.dout    (strap_s)
	);

	always_comb begin
		strap_cnt_d = strap_cnt_q;
		demux_d     = demux_q;
		if (strap_cnt_q != XAG_STRAP_WAIT + 2'd1) begin
			strap_cnt_d = strap_cnt_q + 2'd1;
			if (strap_cnt_q == XAG_STRAP_WAIT) begin
				demux_d = strap_s;
			end
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			strap_cnt_q <= 2'd0;
			demux_q     <= 1'b0;
		end else begin
			strap_cnt_q <= strap_cnt_d;
			demux_q     <= demux_d;
		end
	end

	// ------------------------------------------------------------
	// address generation
	// ------------------------------------------------------------
	assign mode = regs_q.address_control[XAG_MODE_LSB +: 2];

	always_comb begin
		is_prog = (req.kind == XAG_REQ_FETCH) || (req.kind == XAG_REQ_VECTOR);
		unique case (req.kind)
			XAG_REQ_FETCH: begin
				if (mode == XAG_MODE_16) begin
					acc_addr = {8'h00, req.pc[15:0]};
				end else if (mode == XAG_MODE_PAGED) begin
					acc_addr = {regs_q.ap, req.pc[15:0]};
				end else begin
					acc_addr = req.pc;
				end
			end
			XAG_REQ_VECTOR:  acc_addr = {16'h0000, req.pc[7:0]};
			XAG_REQ_POINTER: acc_addr = (mode == XAG_MODE_16) ? {8'h00, req.pointer[15:0]} :
			                            req.pointer;
			XAG_REQ_INDIRECT: acc_addr = {(mode == XAG_MODE_16) ? 8'h00 : regs_q.indirect_extended_byte,
			                              regs_q.p2, req.indirect_register};
		endcase
	end

	// program enables: port 4 gives the lower four, port 6 the upper four
	assign prog_mask = {pin_mask(regs_q.p6[XAG_COUNT_LSB +: 3]),
	                    pin_mask(regs_q.p4[XAG_COUNT_LSB +: 3])};
	assign data_mask = pin_mask(regs_q.p5[XAG_COUNT_LSB +: 3]);

	// size code 000 gives 32kB per enable, 110/111 gives 4MB
	xag_enable_decode #(
		.N        (8),
		.SIZE_MAX (XAG_PROG_SIZE_MAX)
	) u_prog_dec (
		.active    (req.valid && is_prog),
		.addr      (acc_addr),
		.size_code (regs_q.p4[XAG_SIZE_LSB +: 3]),
		.pin_mask  (prog_mask),
		.enable_n  (prog_en_n)
	);

	// data enables reach 32kB to 1MB each, four of them span 4MB
	xag_enable_decode #(
		.N        (4),
		.SIZE_MAX (XAG_DATA_SIZE_MAX)
	) u_data_dec (
		.active    (req.valid && !is_prog),
		.addr      (acc_addr),
		.size_code (regs_q.p6[XAG_SIZE_LSB +: 3]),
		.pin_mask  (data_mask),
		.enable_n  (data_en_n)
	);

	always_comb begin
		pins_d                  = pins_q;
		pins_d.valid            = req.valid;
		pins_d.addr_upper_en    = upper_mask(regs_q.p4[XAG_SIZE_LSB +: 3]);
		pins_d.addr_low_on_p7   = demux_q;
		pins_d.program_enable_n = prog_en_n;
		pins_d.data_enable_n    = data_en_n;
		if (req.valid) begin
			pins_d.address      = acc_addr;
			pins_d.port_two_out = acc_addr[15:8];
			pins_d.addr_low_out = acc_addr[7:0];
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			pins_q <= '{valid: 1'b0, address: 24'h000000, addr_upper_en: 6'h3f,
			            port_two_out: 8'h00, addr_low_out: 8'h00, addr_low_on_p7: 1'b0,
			            program_enable_n: 8'hff, data_enable_n: 4'hf};
		end else begin
			pins_q <= pins_d;
		end
	end

	assign pins = pins_q;

	// ------------------------------------------------------------
	// cycle penalties and stack address
	// ------------------------------------------------------------
	// upper mode bit alone selects contiguous, so 10 and 11 behave alike
	assign timing.addr_mode            = mode;
	assign timing.extra_call_ret_cycle = (mode == XAG_MODE_PAGED);
	assign timing.extra_irq_cycle      = (mode == XAG_MODE_PAGED);
	assign timing.extra_inc_cycle      = mode[1];
	assign timing.pc_full_width        = mode[1];
	assign timing.vector_upper_zero    = (mode == XAG_MODE_PAGED);

	assign stack_address = regs_q.address_control[XAG_STACK_BIT] ? {regs_q.stack_pointer_high, regs_q.sp} :
	                       {8'h00, regs_q.sp};
endmodule

// >>> xag_mem_model.sv
`timescale 1ns/100ps
module xag_mem_model import xag_pkg::*; (
	input  wire logic      mclk,
	input  wire logic      strap_level,
	input  wire xag_pins_t pins,
	output logic           bus_mode_strap,
	output logic [23:0]    seen_addr
);
	// ----------------------------------------
	// board strap and address latch
	// ----------------------------------------
	// strap is a board level, so it stays put across the whole reset
	assign bus_mode_strap = strap_level;
	// external latch grabs the low byte, so muxed data may follow on the port
	always_ff @(posedge mclk) begin
		if (pins.valid) begin
			seen_addr <= {pins.address[23:16], pins.port_two_out, pins.addr_low_out};
		end
	end
endmodule

// >>> xag_chk.sv
`timescale 1ns/100ps
module xag_chk import xag_pkg::*; (
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic        bus_mode_strap,
	input  wire logic [7:0]  sfr_addr,
	input  wire logic        sfr_wr,
	input  wire logic        sfr_rd,
	input  wire logic [7:0]  sfr_wdata,
	input  wire logic [7:0]  sfr_rdata,
	input  wire logic        sfr_hit,
	input  wire xag_req_t    req,
	input  wire xag_pins_t   pins,
	input  wire xag_timing_t timing,
	input  wire logic [15:0] stack_address
);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);

	a_valid_one_late: assert property (1 |=> pins.valid == $past(req.valid))
		else $error("pins valid not one cycle after request");
	a_mode_after_rst: assert property ($past(sys_rst) |->
		timing.addr_mode == XAG_MODE_16)
		else $error("mode not 16-bit after reset");
	a_mode_held: assert property (!(sfr_wr && sfr_addr == XAG_ADDRESS_CONTROL_ADDR) |=>
		$stable(timing.addr_mode))
		else $error("mode moved without a write");
	a_one_enable: assert property (pins.valid |->
		$countones({~pins.program_enable_n, ~pins.data_enable_n}) <= 1)
		else $error("more than one enable low");
	a_idle_enables: assert property (!pins.valid |->
		&{pins.program_enable_n, pins.data_enable_n})
		else $error("enable low without access");
	a_port_bytes: assert property (pins.valid |->
		pins.port_two_out == pins.address[15:8] && pins.addr_low_out == pins.address[7:0])
		else $error("port bytes differ from address");
	a_fetch_narrow: assert property (req.valid && req.kind == XAG_REQ_FETCH &&
		timing.addr_mode == XAG_MODE_16 |=> pins.address == (24'h00ffff & $past(req.pc)))
		else $error("16-bit fetch address wrong");
	a_fetch_wide: assert property (req.valid && req.kind == XAG_REQ_FETCH &&
		timing.addr_mode[1] |=> pins.address == $past(req.pc))
		else $error("contiguous fetch address wrong");
	a_vector_low: assert property (req.valid && req.kind == XAG_REQ_VECTOR |=>
		pins.address == (24'h0000ff & $past(req.pc)))
		else $error("vector upper bytes not zero");
	a_pointer_wide: assert property (req.valid && req.kind == XAG_REQ_POINTER &&
		timing.addr_mode[1] |=> pins.address == $past(req.pointer))
		else $error("pointer address wrong");
	a_paged_flags: assert property (timing.extra_call_ret_cycle ==
		(timing.addr_mode == XAG_MODE_PAGED) &&
		timing.extra_irq_cycle == (timing.addr_mode == XAG_MODE_PAGED))
		else $error("paged extra cycle flags wrong");
	a_contig_flags: assert property (timing.pc_full_width == timing.addr_mode[1] &&
		timing.extra_inc_cycle == timing.addr_mode[1])
		else $error("contiguous flags wrong");
	a_ta_unmapped: assert property (sfr_rd && sfr_addr == XAG_TA_ADDR |=>
		!sfr_hit && sfr_rdata == 8'h00)
		else $error("timed access reads back");

	c_paged_fetch: cover property (req.valid && req.kind == XAG_REQ_FETCH && timing.addr_mode == XAG_MODE_PAGED);
	c_pointer: cover property (req.valid && req.kind == XAG_REQ_POINTER && timing.addr_mode[1]);
	c_data_enable: cover property (pins.valid && !(&pins.data_enable_n));
endmodule

bind xag_addr_gen xag_chk u_chk (
	.mclk          (mclk),
	.sys_rst       (sys_rst),
	.bus_mode_strap(bus_mode_strap),
	.sfr_addr      (sfr_addr),
	.sfr_wr        (sfr_wr),
	.sfr_rd        (sfr_rd),
	.sfr_wdata     (sfr_wdata),
	.sfr_rdata     (sfr_rdata),
	.sfr_hit       (sfr_hit),
	.req           (req),
	.pins          (pins),
	.timing        (timing),
	.stack_address (stack_address)
);

// >>> test_ext_memory_address_gen.sv
`timescale 1ns/100ps
module test_ext_memory_address_gen import xag_pkg::*; ;
	logic        mclk        = 1'b0;
	logic        sys_rst     = 1'b1;
	logic        strap_level = 1'b0;
	logic [7:0]  sfr_addr    = 8'h00;
	logic        sfr_wr      = 1'b0;
	logic        sfr_rd      = 1'b0;
	logic [7:0]  sfr_wdata   = 8'h00;
	xag_req_t    req         = '0;
	logic [7:0]  sfr_rdata;
	logic        sfr_hit;
	xag_pins_t   pins;
	xag_timing_t timing;
	logic [15:0] stack_address;
	logic        bus_mode_strap;
	logic [23:0] seen_addr;
	int          fail_count  = 0;
	int          num_checks  = 0;
	logic [7:0]  ra [9] = '{XAG_SP_ADDR, XAG_P4_ADDR, XAG_ESP_ADDR, XAG_AP_ADDR, XAG_ADDRESS_CONTROL_ADDR,
		XAG_P2_ADDR, XAG_P5_ADDR, XAG_P6_ADDR, XAG_INDIRECT_EXTENDED_BYTE_ADDR};
	logic [7:0]  rv [9] = '{XAG_SP_RST, XAG_P4_RST, XAG_ESP_RST, XAG_AP_RST, XAG_ADDRESS_CONTROL_RST,
		XAG_P2_RST, XAG_P5_RST, XAG_P6_RST, XAG_INDIRECT_EXTENDED_BYTE_RST};
	logic [6:0]  tv [4] = '{7'h00, 7'h39, 7'h46, 7'h66};
	logic [23:0] fa [4] = '{24'h00abcd, 24'h5aabcd, 24'h89abcd, 24'h89abcd};
	logic [23:0] ia [4] = '{24'h001277, 24'h3c1277, 24'h3c1277, 24'h3c1277};

	xag_addr_gen dut (.mclk(mclk), .sys_rst(sys_rst), .bus_mode_strap(bus_mode_strap),
		.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .req(req), .pins(pins), .timing(timing),
		.stack_address(stack_address));
	xag_mem_model u_mem (.mclk(mclk), .strap_level(strap_level), .pins(pins),
		.bus_mode_strap(bus_mode_strap), .seen_addr(seen_addr));

	always #5 mclk = ~mclk;

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// strap stays put from reset entry through the capture edges
	task automatic do_reset(input logic s);
		strap_level = s;
		sys_rst = 1'b1;
		repeat (8) @(negedge mclk);
		sys_rst = 1'b0;
		repeat (4) @(negedge mclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge mclk);
		sfr_wr = 1'b0;
	endtask

	task automatic ta_wr(input logic [7:0] a, input logic [7:0] d);
		wr(XAG_TA_ADDR, XAG_TA_KEY1);
		wr(XAG_TA_ADDR, XAG_TA_KEY2);
		wr(a, d);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic hit);
		@(negedge mclk);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge mclk);
		sfr_rd = 1'b0;
		chk(24'(sfr_rdata), 24'(exp));
		chk(24'(sfr_hit), 24'(hit));
	endtask

	// one request cycle; pins are settled at the closing falling edge
	task automatic acc(input xag_kind_t k, input logic [23:0] a, input logic [7:0] ri);
		@(negedge mclk);
		req = '{valid: 1'b1, kind: k, pc: a, pointer: a, indirect_register: ri};
		@(negedge mclk);
		req.valid = 1'b0;
	endtask

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		int sh;
		do_reset(1'b0);
		for (int i = 0; i < 9; i++) begin
			rd_chk(ra[i], rv[i], 1'b1);
		end
		rd_chk(XAG_TA_ADDR, 8'h00, 1'b0);
		chk(24'(stack_address), 24'({8'h00, XAG_SP_RST}));
		chk(24'(timing), 24'h000000);
		acc(XAG_REQ_FETCH, 24'h012345, 8'h00);
		chk(pins.address, 24'h002345);
		chk(24'({pins.program_enable_n, pins.port_two_out}), 24'hfe23);
		chk(24'({pins.addr_low_on_p7, pins.addr_upper_en}), 24'h3f);
		@(negedge mclk);
		chk(seen_addr, 24'h002345);
		wr(XAG_ADDRESS_CONTROL_ADDR, 8'h01);
		rd_chk(XAG_ADDRESS_CONTROL_ADDR, 8'h00, 1'b1);
		wr(XAG_AP_ADDR, 8'h5a);
		wr(XAG_P2_ADDR, 8'h12);
		wr(XAG_INDIRECT_EXTENDED_BYTE_ADDR, 8'h3c);
		wr(XAG_ESP_ADDR, 8'h02);
		for (int m = 0; m < 4; m++) begin
			ta_wr(XAG_ADDRESS_CONTROL_ADDR, 8'(m + 4));
			chk(24'(timing), 24'(tv[m]));
			acc(XAG_REQ_FETCH, 24'h89abcd, 8'h00);
			chk(pins.address, fa[m]);
			acc(XAG_REQ_POINTER, 24'h89abcd, 8'h00);
			chk(pins.address, (m == 0) ? 24'h00abcd : 24'h89abcd);
			acc(XAG_REQ_INDIRECT, 24'h000000, 8'h77);
			chk(pins.address, ia[m]);
			acc(XAG_REQ_VECTOR, 24'h3412ab, 8'h00);
			chk(pins.address, 24'h0000ab);
		end
		chk(24'(stack_address), 24'h0207);
		// window closes after one protected write
		wr(XAG_P4_ADDR, 8'h00);
		rd_chk(XAG_P4_ADDR, XAG_P4_RST, 1'b1);
		for (int s = 0; s < 8; s++) begin
			sh = (s == 0) ? 15 : (s < 6) ? 16 + s : 22;
			ta_wr(XAG_P4_ADDR, 8'(s * 8 + 7));
			acc(XAG_REQ_FETCH, 24'(1 << sh), 8'h00);
			chk(24'(pins.program_enable_n), 24'hfd);
			chk(24'(pins.addr_upper_en), (s < 6) ? 24'((1 << s) - 1) : 24'h3f);
			if (s < 6) begin
				acc(XAG_REQ_FETCH, 24'(4 << sh), 8'h00);
				chk(24'(pins.program_enable_n), 24'hff);
			end
		end
		for (int c = 0; c < 5; c++) begin
			ta_wr(XAG_P4_ADDR, (c < 4) ? 8'(8'h3c + c) : 8'h38);
			acc(XAG_REQ_FETCH, 24'((c % 4) << 22), 8'h00);
			chk(24'(pins.program_enable_n), (c < 4) ? 24'(8'hff ^ (8'h01 << c)) : 24'hff);
		end
		ta_wr(XAG_P5_ADDR, 8'h05);
		ta_wr(XAG_P6_ADDR, 8'h08);
		acc(XAG_REQ_POINTER, 24'h020000, 8'h00);
		chk(24'({pins.program_enable_n, pins.data_enable_n}), 24'hffd);
		acc(XAG_REQ_POINTER, 24'h040000, 8'h00);
		chk(24'(pins.data_enable_n), 24'hf);
		ta_wr(XAG_P5_ADDR, 8'h07);
		ta_wr(XAG_P6_ADDR, 8'h20);
		acc(XAG_REQ_POINTER, 24'h300000, 8'h00);
		chk(24'(pins.data_enable_n), 24'h7);
		do_reset(1'b1);
		acc(XAG_REQ_FETCH, 24'h000010, 8'h00);
		chk(24'({pins.addr_low_on_p7, timing.addr_mode}), 24'h4);
		end_sim();
	end

	// a full run takes a few hundred cycles; this cuts a hang short
	initial begin
		#100000;
		fail_count++;
		end_sim();
	end
endmodule
